// ### hw/txdrv_pkg.sv
package txdrv_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_DRIVER_MODE = 8'h28;
	localparam logic [7:0] ADDR_CARRIER_AMP = 8'h29;
	localparam logic [7:0] ADDR_MOD_CONTROL = 8'h2a;
	localparam logic [7:0] ADDR_LOAD_OVERSHOOT = 8'h2b;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BIT_SECOND_INVERT = 7;
	localparam int BIT_FIRST_INVERT = 6;
	localparam int BIT_DRIVER_ENABLE = 3;
	localparam int BIT_CLK_MODE_LO = 0;
	localparam int BIT_AMP_RED_LO = 6;
	localparam int BIT_RESIDUAL_LO = 0;
	localparam int BIT_SECOND_OVS_LO = 4;
	localparam int BIT_CARRIER_MAX = 3;
	localparam int BIT_MOD_INVERT = 2;
	localparam int BIT_MOD_SEL_LO = 0;
	localparam int BIT_FIRST_OVS_LO = 4;
	localparam int BIT_LOAD_TRIM_LO = 0;

	// Writable bit masks; reserved bits are held at zero
	localparam logic [7:0] MASK_DRIVER_MODE = 8'hcf;
	localparam logic [7:0] MASK_CARRIER_AMP = 8'hdf;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_DRIVER_MODE = 8'h00;
	localparam logic [7:0] RST_CARRIER_AMP = 8'h00;
	localparam logic [7:0] RST_MOD_CONTROL = 8'h00;
	localparam logic [7:0] RST_LOAD_OVERSHOOT = 8'h00;

	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	localparam logic [2:0] CLK_MODE_HIGH_Z = 3'h0;
	localparam logic [2:0] CLK_MODE_OPEN_DRAIN = 3'h1;
	localparam logic [2:0] CLK_MODE_PUSH_PULL = 3'h2;
	localparam logic [2:0] CLK_MODE_BAD_A = 3'h3;
	localparam logic [2:0] CLK_MODE_FIX_LOW = 3'h4;
	localparam logic [2:0] CLK_MODE_FIX_HIGH = 3'h5;
	localparam logic [2:0] CLK_MODE_BAD_B = 3'h6;
	localparam logic [2:0] CLK_MODE_OPEN_SRC = 3'h7;

	localparam logic [1:0] MOD_SEL_NONE = 2'h0;
	localparam logic [1:0] MOD_SEL_ENVELOPE = 2'h1;
	localparam logic [1:0] MOD_SEL_SERIAL = 2'h2;

	localparam logic [10:0] AMP_RED_MV_0 = 11'h064;
	localparam logic [10:0] AMP_RED_MV_1 = 11'h0fa;
	localparam logic [10:0] AMP_RED_MV_2 = 11'h1f4;
	localparam logic [10:0] AMP_RED_MV_3 = 11'h3e8;

endpackage : txdrv_pkg

// ### hw/txdrv_cfg_if.sv
interface txdrv_cfg_if;
	logic second_driver_invert;
	logic first_driver_invert;
	logic driver_enable;
	logic [2:0] driver_clock_mode;
	logic modulation_invert;
	logic [1:0] modulation_source_select;

	modport src (
		output second_driver_invert, first_driver_invert, driver_enable,
		output driver_clock_mode, modulation_invert, modulation_source_select
	);
	modport dst (
		input second_driver_invert, first_driver_invert, driver_enable,
		input driver_clock_mode, modulation_invert, modulation_source_select
	);
endinterface : txdrv_cfg_if

// ### hw/txdrv_pin_stage.sv
module txdrv_pin_stage
	import txdrv_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst,
	txdrv_cfg_if.dst cfg,
	input wire logic i_carrier,
	input wire logic i_envelope,
	input wire logic i_serial_sync,
	output logic o_mod,
	output logic o_first_out,
	output logic o_first_oe_n,
	output logic o_second_out,
	output logic o_second_oe_n
);

	typedef struct packed {
		logic mod;
		logic first_out;
		logic first_oe_n;
		logic second_out;
		logic second_oe_n;
	} stage_s;

	stage_s st_ff;
	stage_s nxt_st;

	// Drive value and enable for one pin in the selected mode
	function automatic logic [1:0] pin_drive(input logic [2:0] mode, input logic lvl,
		input logic en);
		logic [1:0] r;
		r = 2'b01;
		if (en) begin
			unique case (mode)
				CLK_MODE_PUSH_PULL: r = {lvl, 1'b0};
				CLK_MODE_OPEN_DRAIN: r = {1'b0, lvl};
				CLK_MODE_OPEN_SRC: r = {1'b1, ~lvl};
				CLK_MODE_FIX_LOW: r = 2'b00;
				CLK_MODE_FIX_HIGH: r = 2'b10;
				default: r = 2'b01;
			endcase
		end
		return r;
	endfunction : pin_drive

	always_comb begin
		logic src;
		logic m;
		logic l1;
		logic l2;
		src = 1'b0;
		m = 1'b0;
		l1 = 1'b0;
		l2 = 1'b0;
		unique case (cfg.modulation_source_select)
			MOD_SEL_ENVELOPE: src = i_envelope;
			MOD_SEL_SERIAL: src = i_serial_sync;
			default: src = 1'b0;
		endcase
		m = src ^ cfg.modulation_invert;
		l1 = i_carrier ^ cfg.first_driver_invert;
		l2 = i_carrier ^ cfg.second_driver_invert;
		nxt_st.mod = m;
		{nxt_st.first_out, nxt_st.first_oe_n} = pin_drive(cfg.driver_clock_mode, l1,
			cfg.driver_enable);
		{nxt_st.second_out, nxt_st.second_oe_n} = pin_drive(cfg.driver_clock_mode, l2,
			cfg.driver_enable);
		if (i_rst) begin
			nxt_st = '{mod: 1'b0, first_out: 1'b0, first_oe_n: 1'b1, second_out: 1'b0,
				second_oe_n: 1'b1};
		end
	end

	always_ff @(posedge i_core_clk) begin
		st_ff <= nxt_st;
	end

	assign o_mod = st_ff.mod;
	assign o_first_out = st_ff.first_out;
	assign o_first_oe_n = st_ff.first_oe_n;
	assign o_second_out = st_ff.second_out;
	assign o_second_oe_n = st_ff.second_oe_n;

endmodule : txdrv_pin_stage

// ### hw/rf_transmitter_driver_config.sv
// How it works
// - Second driver inversion bit inverts the second pin's signal.
// - First driver inversion bit inverts the first pin's signal.
// - Driver enable bit enables both driver pins together.
// - Clock mode field picks open-drain, high-side-only, push-pull, high-Z, fixed high or low.
// - Amplitude reduction code 0..3 gives 100, 250, 500, 1000 mV below supply.
// - Maximum-carrier bit forces full amplitude and ignores the reduction field.
// - Modulation invert bit inverts the selected modulation source.
// - Source select: none, internal envelope, external serial input; 11 reserved.
// - Second overshoot field gives extra modulation length in carrier cycles.
// - First overshoot field holds the first overshoot timer value.
// - Load current trim field holds expected load current trim.
// - Residual carrier field sets residual carrier percentage.
//
// The address-and-strobe port is this design's own decision.
module rf_transmitter_driver_config
	import txdrv_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_carrier,
	input wire logic i_internal_transmit_envelope,
	input wire logic i_external_serial_signal_input,
	output logic o_first_driver_pin_out,
	output logic o_first_driver_pin_oe_n,
	output logic o_second_driver_pin_out,
	output logic o_second_driver_pin_oe_n,
	output logic o_modulation,
	output logic o_carrier_max,
	output logic [10:0] o_amp_reduction_mv,
	output logic [4:0] o_residual_carrier,
	output logic [3:0] o_second_overshoot_length,
	output logic [3:0] o_first_overshoot_value,
	output logic [3:0] o_load_current_trim,
	output logic o_clock_mode_unsupported
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] driver_mode;
		logic [7:0] carrier_amp;
		logic [7:0] mod_control;
		logic [7:0] load_overshoot;
		logic [7:0] rdata;
		logic [1:0] serial_sync;
		logic carrier_max;
		logic [10:0] amp_mv;
		logic [4:0] residual;
		logic [3:0] second_ovs;
		logic [3:0] first_ovs;
		logic [3:0] load_trim;
		logic clk_bad;
	} regs_s;

	regs_s st_ff;
	regs_s nxt_st;

	// Amplitude reduction lookup
	function automatic logic [10:0] reduction_mv(input logic [1:0] code);
		logic [10:0] v;
		v = AMP_RED_MV_0;
		unique case (code)
			2'h0: v = AMP_RED_MV_0;
			2'h1: v = AMP_RED_MV_1;
			2'h2: v = AMP_RED_MV_2;
			2'h3: v = AMP_RED_MV_3;
		endcase
		return v;
	endfunction : reduction_mv

	// ------------------------------------------------------------
	// Register file and derived settings
	// ------------------------------------------------------------
	always_comb begin
		logic [1:0] red;
		red = 2'h0;
		nxt_st = st_ff;
		nxt_st.serial_sync = {st_ff.serial_sync[0], i_external_serial_signal_input};
		if (i_wr) begin
			unique case (i_addr)
				ADDR_DRIVER_MODE: nxt_st.driver_mode = i_wdata & MASK_DRIVER_MODE;
				ADDR_CARRIER_AMP: nxt_st.carrier_amp = i_wdata & MASK_CARRIER_AMP;
				ADDR_MOD_CONTROL: nxt_st.mod_control = i_wdata;
				ADDR_LOAD_OVERSHOOT: nxt_st.load_overshoot = i_wdata;
				default: ;
			endcase
		end
		nxt_st.rdata = 8'h00;
		if (i_rd) begin
			unique case (i_addr)
				ADDR_DRIVER_MODE: nxt_st.rdata = st_ff.driver_mode;
				ADDR_CARRIER_AMP: nxt_st.rdata = st_ff.carrier_amp;
				ADDR_MOD_CONTROL: nxt_st.rdata = st_ff.mod_control;
				ADDR_LOAD_OVERSHOOT: nxt_st.rdata = st_ff.load_overshoot;
				default: nxt_st.rdata = 8'h00;
			endcase
		end
		red = st_ff.carrier_amp[BIT_AMP_RED_LO +: 2];
		nxt_st.carrier_max = st_ff.mod_control[BIT_CARRIER_MAX];
		nxt_st.amp_mv = st_ff.mod_control[BIT_CARRIER_MAX] ? 11'h000 : reduction_mv(red);
		nxt_st.residual = st_ff.carrier_amp[BIT_RESIDUAL_LO +: 5];
		nxt_st.second_ovs = st_ff.mod_control[BIT_SECOND_OVS_LO +: 4];
		nxt_st.first_ovs = st_ff.load_overshoot[BIT_FIRST_OVS_LO +: 4];
		nxt_st.load_trim = st_ff.load_overshoot[BIT_LOAD_TRIM_LO +: 4];
		// Flag codes that software must not program
		nxt_st.clk_bad = (st_ff.driver_mode[BIT_CLK_MODE_LO +: 3] == CLK_MODE_BAD_A) ||
			(st_ff.driver_mode[BIT_CLK_MODE_LO +: 3] == CLK_MODE_BAD_B);
		if (i_rst) begin
			nxt_st = '0;
			nxt_st.driver_mode = RST_DRIVER_MODE;
			nxt_st.carrier_amp = RST_CARRIER_AMP;
			nxt_st.mod_control = RST_MOD_CONTROL;
			nxt_st.load_overshoot = RST_LOAD_OVERSHOOT;
			nxt_st.amp_mv = AMP_RED_MV_0;
		end
	end

	always_ff @(posedge i_core_clk) begin
		st_ff <= nxt_st;
	end

	// ------------------------------------------------------------
	// Pin stage
	// ------------------------------------------------------------
	txdrv_cfg_if cfg_bus ();

	assign cfg_bus.second_driver_invert = st_ff.driver_mode[BIT_SECOND_INVERT];
	assign cfg_bus.first_driver_invert = st_ff.driver_mode[BIT_FIRST_INVERT];
	assign cfg_bus.driver_enable = st_ff.driver_mode[BIT_DRIVER_ENABLE];
	assign cfg_bus.driver_clock_mode = st_ff.driver_mode[BIT_CLK_MODE_LO +: 3];
	assign cfg_bus.modulation_invert = st_ff.mod_control[BIT_MOD_INVERT];
	assign cfg_bus.modulation_source_select = st_ff.mod_control[BIT_MOD_SEL_LO +: 2];

	txdrv_pin_stage u_pin_stage (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.cfg(cfg_bus.dst),
		.i_carrier(i_carrier),
		.i_envelope(i_internal_transmit_envelope),
		.i_serial_sync(st_ff.serial_sync[1]),
		.o_mod(o_modulation),
		.o_first_out(o_first_driver_pin_out),
		.o_first_oe_n(o_first_driver_pin_oe_n),
		.o_second_out(o_second_driver_pin_out),
		.o_second_oe_n(o_second_driver_pin_oe_n)
	);

	assign o_rdata = st_ff.rdata;
	assign o_carrier_max = st_ff.carrier_max;
	assign o_amp_reduction_mv = st_ff.amp_mv;
	assign o_residual_carrier = st_ff.residual;
	assign o_second_overshoot_length = st_ff.second_ovs;
	assign o_first_overshoot_value = st_ff.first_ovs;
	assign o_load_current_trim = st_ff.load_trim;
	assign o_clock_mode_unsupported = st_ff.clk_bad;

endmodule : rf_transmitter_driver_config

// ### verification/txdrv_antenna_model.sv
module txdrv_antenna_model
(
	input wire logic i_core_clk,
	input wire logic i_out,
	input wire logic i_oe_n,
	output logic o_level
);
	timeunit 1ns;
	timeprecision 1ns;
	logic last_ff = 1'b0;
	// A released pin keeps changing, so a stale level never passes for a drive
	assign o_level = i_oe_n ? ~last_ff : i_out;
	always_ff @(posedge i_core_clk) begin
		last_ff <= o_level;
	end
endmodule : txdrv_antenna_model

// ### verification/rf_transmitter_driver_config_checker.sv
module rf_transmitter_driver_config_checker
	import txdrv_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic o_first_driver_pin_oe_n,
	input wire logic o_second_driver_pin_oe_n,
	input wire logic o_carrier_max,
	input wire logic [10:0] o_amp_reduction_mv,
	input wire logic [4:0] o_residual_carrier,
	input wire logic [3:0] o_second_overshoot_length,
	input wire logic [3:0] o_first_overshoot_value,
	input wire logic [3:0] o_load_current_trim
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	property p_rdata_idle;
		!$past(i_rd) |-> o_rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
	property p_mode_rsvd;
		$past(i_rd) && $past(i_addr) == ADDR_DRIVER_MODE |-> o_rdata[5:4] == 2'h0;
	endproperty
	a_mode_rsvd: assert property (p_mode_rsvd) else $error("mode spare bits set");
	property p_amp_rsvd;
		$past(i_rd) && $past(i_addr) == ADDR_CARRIER_AMP |-> o_rdata[5] == 1'b0;
	endproperty
	a_amp_rsvd: assert property (p_amp_rsvd) else $error("amp spare bit set");
	property p_cmax;
		o_carrier_max |-> o_amp_reduction_mv == 11'h000;
	endproperty
	a_cmax: assert property (p_cmax) else $error("reduction under max carrier");
	property p_amp_map;
		(i_wr && i_addr == ADDR_CARRIER_AMP) ##2 !o_carrier_max |-> o_amp_reduction_mv ==
			($past(i_wdata[7:6], 2) == 2'h0 ? AMP_RED_MV_0 : $past(i_wdata[7:6], 2) == 2'h1 ?
			AMP_RED_MV_1 : $past(i_wdata[7:6], 2) == 2'h2 ? AMP_RED_MV_2 : AMP_RED_MV_3);
	endproperty
	a_amp_map: assert property (p_amp_map) else $error("reduction code wrong");
	property p_resid;
		(i_wr && i_addr == ADDR_CARRIER_AMP) |-> ##2 o_residual_carrier == $past(i_wdata[4:0], 2);
	endproperty
	a_resid: assert property (p_resid) else $error("residual field wrong");
	property p_ovs2;
		(i_wr && i_addr == ADDR_MOD_CONTROL) |-> ##2
			o_second_overshoot_length == $past(i_wdata[7:4], 2);
	endproperty
	a_ovs2: assert property (p_ovs2) else $error("second overshoot wrong");
	property p_load;
		(i_wr && i_addr == ADDR_LOAD_OVERSHOOT) |-> ##2
			{o_first_overshoot_value, o_load_current_trim} == $past(i_wdata, 2);
	endproperty
	a_load: assert property (p_load) else $error("load register fields wrong");
	property p_off;
		(i_wr && i_addr == ADDR_DRIVER_MODE && !i_wdata[3]) ##1 (!i_wr) [*2] |=>
			o_first_driver_pin_oe_n && o_second_driver_pin_oe_n;
	endproperty
	a_off: assert property (p_off) else $error("pin driven while off");
endmodule : rf_transmitter_driver_config_checker

bind rf_transmitter_driver_config rf_transmitter_driver_config_checker chk (.i_core_clk, .i_rst,
	.i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_first_driver_pin_oe_n, .o_second_driver_pin_oe_n,
	.o_carrier_max, .o_amp_reduction_mv, .o_residual_carrier, .o_second_overshoot_length,
	.o_first_overshoot_value, .o_load_current_trim);

// ### verification/rf_transmitter_driver_config_test.sv
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
	$display("wrong value %s exp %0h got %0h", nm, e, g); end end
module rf_transmitter_driver_config_test
	import txdrv_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_core_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_carrier = 1'b0;
	logic i_internal_transmit_envelope = 1'b1, i_external_serial_signal_input = 1'b0;
	logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
	logic o_first_driver_pin_out, o_first_driver_pin_oe_n, o_second_driver_pin_out;
	logic o_second_driver_pin_oe_n, o_modulation, o_carrier_max, o_clock_mode_unsupported;
	logic lvl1, lvl2;
	logic [10:0] o_amp_reduction_mv;
	logic [4:0] o_residual_carrier;
	logic [3:0] o_second_overshoot_length, o_first_overshoot_value, o_load_current_trim;
	logic [10:0] mv_tab [4] = '{11'h064, 11'h0fa, 11'h1f4, 11'h3e8};
	// Only supported clock modes are ever written
	logic [2:0] modes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h7};
	logic [1:0] e1, e2;
	int n_errors = 0, compares = 0, cyc = 0;
	rf_transmitter_driver_config uut (.i_core_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
		.o_rdata, .i_carrier, .i_internal_transmit_envelope, .i_external_serial_signal_input,
		.o_first_driver_pin_out, .o_first_driver_pin_oe_n, .o_second_driver_pin_out,
		.o_second_driver_pin_oe_n, .o_modulation, .o_carrier_max, .o_amp_reduction_mv,
		.o_residual_carrier, .o_second_overshoot_length, .o_first_overshoot_value,
		.o_load_current_trim, .o_clock_mode_unsupported);
	txdrv_antenna_model ant1 (.i_core_clk, .i_out(o_first_driver_pin_out),
		.i_oe_n(o_first_driver_pin_oe_n), .o_level(lvl1));
	txdrv_antenna_model ant2 (.i_core_clk, .i_out(o_second_driver_pin_out),
		.i_oe_n(o_second_driver_pin_oe_n), .o_level(lvl2));
	always #20 i_core_clk = ~i_core_clk;
	task automatic tally_and_finish();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	always @(posedge i_core_clk) begin
		cyc++;
		if (cyc == 2000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge i_core_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 `CHK("rdata", e, o_rdata)
	endtask : rd_chk
	// Expected {oe_n, out} for a clock mode and a pin level
	function automatic logic [1:0] pin(input logic [2:0] m, input logic l);
		case (m)
			3'h1: pin = l ? 2'b10 : 2'b00;
			3'h2: pin = {1'b0, l};
			3'h4: pin = 2'b00;
			3'h5: pin = 2'b01;
			3'h7: pin = l ? 2'b01 : 2'b10;
			default: pin = 2'b10;
		endcase
	endfunction : pin
	initial begin
		repeat (6) @(posedge i_core_clk);
		i_rst <= 1'b0;
		for (int a = 8'h28; a < 8'h2c; a++) rd_chk(8'(a), 8'h00);
		`CHK("oe1", 1'b1, o_first_driver_pin_oe_n)
		wr_reg(ADDR_DRIVER_MODE, 8'hff);
		rd_chk(ADDR_DRIVER_MODE, 8'hcf);
		wr_reg(ADDR_CARRIER_AMP, 8'hff);
		rd_chk(ADDR_CARRIER_AMP, 8'hdf);
		wr_reg(ADDR_MOD_CONTROL, 8'h5a);
		rd_chk(ADDR_MOD_CONTROL, 8'h5a);
		wr_reg(ADDR_LOAD_OVERSHOOT, 8'hc3);
		rd_chk(ADDR_LOAD_OVERSHOOT, 8'hc3);
		wr_reg(8'h30, 8'hff);
		rd_chk(8'h30, 8'h00);
		`CHK("ovs1", 4'hc, o_first_overshoot_value)
		`CHK("trim", 4'h3, o_load_current_trim)
		`CHK("ovs2", 4'h5, o_second_overshoot_length)
		`CHK("resid", 5'h1f, o_residual_carrier)
		`CHK("mv_max", 11'h000, o_amp_reduction_mv)
		`CHK("cmax", 1'b1, o_carrier_max)
		for (int m = 0; m < 16; m++) begin
			i_internal_transmit_envelope <= !m[3];
			i_external_serial_signal_input <= m[3];
			wr_reg(ADDR_MOD_CONTROL, {5'h00, m[2:0]});
			repeat (4) @(posedge i_core_clk);
			e1[0] = ((m[1:0] == 2'h1) && !m[3]) || ((m[1:0] == 2'h2) && m[3]);
			`CHK("mod", e1[0] ^ m[2], o_modulation)
		end
		for (int c = 0; c < 4; c++) begin
			wr_reg(ADDR_CARRIER_AMP, {c[1:0], 6'h00});
			repeat (3) @(posedge i_core_clk);
			`CHK("mv", mv_tab[c], o_amp_reduction_mv)
		end
		for (int k = 0; k < 12; k++) begin
			i_carrier <= k[0];
			wr_reg(ADDR_DRIVER_MODE, {4'h4, 1'b1, modes[k / 2]});
			repeat (4) @(posedge i_core_clk);
			e1 = pin(modes[k / 2], !k[0]);
			e2 = pin(modes[k / 2], k[0]);
			`CHK("oe1", e1[1], o_first_driver_pin_oe_n)
			`CHK("oe2", e2[1], o_second_driver_pin_oe_n)
			`CHK("unsup", 1'b0, o_clock_mode_unsupported)
			if (!e1[1]) `CHK("pin1", e1[0], lvl1)
			if (!e2[1]) `CHK("pin2", e2[0], lvl2)
		end
		wr_reg(ADDR_DRIVER_MODE, 8'h02);
		repeat (4) @(posedge i_core_clk);
		`CHK("off", 2'b11, {o_first_driver_pin_oe_n, o_second_driver_pin_oe_n})
		// Mid-run reset; check the amplitude and modulation registers and the amplitude outputs return to reset values
		i_rst <= 1'b1;
		repeat (2) @(posedge i_core_clk);
		i_rst <= 1'b0;
		rd_chk(ADDR_CARRIER_AMP, RST_CARRIER_AMP);
		rd_chk(ADDR_MOD_CONTROL, RST_MOD_CONTROL);
		`CHK("mv_rst", AMP_RED_MV_0, o_amp_reduction_mv)
		`CHK("cmax_rst", 1'b0, o_carrier_max)
		tally_and_finish();
	end
endmodule : rf_transmitter_driver_config_test
